/* File: src/pa_accum.sv */
// pulse accumulator: 16-bit event counter / gated time accumulator with apb registers
// assumes a synchronous apb master on REF_CLK and an asynchronous channel 7 pin
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module pa_accum (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // channel 7 pin and timer prescaler
  input  wire logic        CH7_PIN,
  input  wire logic        PRESCALER_TICK,
  // timer counter clock enable and interrupts
  output logic             TCNT_CLK_EN,
  output logic             PA_OVF_IRQ,
  output logic             PA_IN_IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  pa_pkg::pa_state_type s_ff;
  pa_pkg::pa_state_type nxt_s;

  logic       en;
  logic       mode;
  logic       pol;
  logic       rise;
  logic       fall;
  logic       hit;
  logic       div_tick;
  logic       gate;
  logic       inc;
  logic       access;
  logic       wr;
  logic [5:0] idx;
  logic [1:0] clr;
  logic [1:0] set;
  logic       cnt_wr;
  logic       cnt_touch;

  function automatic logic mapped(input logic [5:0] i);
    mapped = (i == pa_pkg::IDX_TIMER_SYS) || (i == pa_pkg::IDX_CONTROL) ||
             (i == pa_pkg::IDX_FLAGS) || (i == pa_pkg::IDX_CNT_HIGH) ||
             (i == pa_pkg::IDX_CNT_LOW) || (i == pa_pkg::IDX_CNT_WORD);
  endfunction

  function automatic logic is_count(input logic [5:0] i);
    is_count = (i == pa_pkg::IDX_CNT_HIGH) || (i == pa_pkg::IDX_CNT_LOW) ||
               (i == pa_pkg::IDX_CNT_WORD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;

    // pin crossing: only the second and third stages feed logic
    nxt_s.sync1 = CH7_PIN;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.prev  = s_ff.sync2;

    en   = s_ff.ctl[pa_pkg::CTL_ENABLE];
    mode = s_ff.ctl[pa_pkg::CTL_MODE];
    pol  = s_ff.ctl[pa_pkg::CTL_EDGE];
    rise = s_ff.sync2 & ~s_ff.prev;
    fall = ~s_ff.sync2 & s_ff.prev;

    // selected edge is the counted edge in event mode and the trailing gate edge in gated mode
    hit = en & (pol ? rise : fall);

    // divide-by-64 of REF_CLK, which stops while the timer is off
    div_tick    = s_ff.timer_enable & (s_ff.presc == pa_pkg::DIV64_LAST);
    nxt_s.presc = s_ff.timer_enable ? s_ff.presc + 6'h01 : 6'h00;

    gate = en & mode & (s_ff.sync2 != pol);
    inc  = en & (mode ? (gate & div_tick) : hit);

    // apb decode; a zero-wait slave, so every access completes at its first access cycle
    access = PSEL & PENABLE;
    wr     = access & PWRITE;
    idx    = PADDR[7:2];

    // counting; a software write in the same cycle overrides the increment in the bytes it writes
    set = 2'h0;
    if (inc) begin
      nxt_s.cnt = s_ff.cnt + 16'h0001;
    end
    cnt_wr = wr & is_count(idx) & (PADDR[1:0] == 2'h0);
    if (cnt_wr) begin
      if (idx == pa_pkg::IDX_CNT_HIGH) begin
        nxt_s.cnt[15:8] = PWDATA[7:0];
      end else if (idx == pa_pkg::IDX_CNT_LOW) begin
        nxt_s.cnt[7:0] = PWDATA[7:0];
      end else begin
        nxt_s.cnt = PWDATA[15:0];
      end
    end
    if (inc && !cnt_wr && s_ff.cnt == pa_pkg::COUNT_MAX) begin
      set[pa_pkg::FLG_OVF] = 1'b1;
    end
    if (hit) begin
      set[pa_pkg::FLG_IN] = 1'b1;
    end

    // flag clearing; a set in the same cycle wins
    clr = 2'h0;
    if (wr && idx == pa_pkg::IDX_FLAGS && PADDR[1:0] == 2'h0) begin
      clr = PWDATA[1:0];
    end
    cnt_touch = access & is_count(idx) & (PADDR[1:0] == 2'h0);
    if (cnt_touch && s_ff.ffc) begin
      clr = 2'h3;
    end
    nxt_s.flags = (s_ff.flags & ~clr) | set;

    // control writes
    if (wr && PADDR[1:0] == 2'h0) begin
      if (idx == pa_pkg::IDX_CONTROL) begin
        nxt_s.ctl = PWDATA[6:0];
      end
      if (idx == pa_pkg::IDX_TIMER_SYS) begin
        nxt_s.timer_enable = PWDATA[pa_pkg::TSC_TEN];
        nxt_s.ffc = PWDATA[pa_pkg::TSC_FFC];
      end
    end

    // read data is captured in the setup cycle; a count edge landing in between is not seen
    if (PSEL && !PENABLE) begin
      nxt_s.slverr = !mapped(idx) || (PADDR[1:0] != 2'h0);
      nxt_s.rdata  = 32'h0000_0000;
      case (idx)
        pa_pkg::IDX_TIMER_SYS: begin
          nxt_s.rdata[pa_pkg::TSC_TEN] = s_ff.timer_enable;
          nxt_s.rdata[pa_pkg::TSC_FFC] = s_ff.ffc;
        end
        pa_pkg::IDX_CONTROL:  nxt_s.rdata[6:0]  = s_ff.ctl;
        pa_pkg::IDX_FLAGS:    nxt_s.rdata[1:0]  = s_ff.flags;
        pa_pkg::IDX_CNT_HIGH: nxt_s.rdata[7:0]  = s_ff.cnt[15:8];
        pa_pkg::IDX_CNT_LOW:  nxt_s.rdata[7:0]  = s_ff.cnt[7:0];
        pa_pkg::IDX_CNT_WORD: nxt_s.rdata[15:0] = s_ff.cnt;
        default:              nxt_s.rdata       = 32'h0000_0000;
      endcase
      if (PADDR[1:0] != 2'h0) begin
        nxt_s.rdata = 32'h0000_0000;
      end
    end

    // accumulator clock divider for the /256 and /65536 timer clocks
    if (inc) begin
      nxt_s.clkdiv = s_ff.clkdiv + 16'h0001;
    end

    // timer counter clock, switched from the live select bits with no resync
    if (!en) begin
      nxt_s.tclk = PRESCALER_TICK;
    end else begin
      case (s_ff.ctl[pa_pkg::CTL_CLK_HI:pa_pkg::CTL_CLK_LO])
        pa_pkg::CLK_PRESCALER: nxt_s.tclk = PRESCALER_TICK;
        pa_pkg::CLK_ACCUM:     nxt_s.tclk = inc;
        pa_pkg::CLK_ACCUM_256: nxt_s.tclk = inc & (s_ff.clkdiv[7:0] == pa_pkg::DIV256_LAST);
        pa_pkg::CLK_ACCUM_64K: nxt_s.tclk = inc & (s_ff.clkdiv == pa_pkg::COUNT_MAX);
        default:               nxt_s.tclk = PRESCALER_TICK;
      endcase
    end

    // interrupt requests, one per source
    nxt_s.irq_ovf = nxt_s.flags[pa_pkg::FLG_OVF] & nxt_s.ctl[pa_pkg::CTL_OVF_IE];
    nxt_s.irq_in  = nxt_s.flags[pa_pkg::FLG_IN] & nxt_s.ctl[pa_pkg::CTL_IN_IE];
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_ff        <= '0;
      s_ff.ctl    <= pa_pkg::CONTROL_RST;
      s_ff.flags  <= pa_pkg::FLAGS_RST;
      s_ff.cnt    <= pa_pkg::COUNT_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign PRDATA      = s_ff.rdata;
  assign PSLVERR     = s_ff.slverr & PSEL & PENABLE;
  assign PREADY      = PSEL & PENABLE;
  assign TCNT_CLK_EN = s_ff.tclk;
  assign PA_OVF_IRQ  = s_ff.irq_ovf;
  assign PA_IN_IRQ   = s_ff.irq_in;

endmodule

/* File: common/pa_pkg.sv */
// pulse accumulator package: register indices, field positions, reset values, state record
// assumes a 32-bit apb slave where each register takes one word at byte address 4*index
package pa_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_TIMER_SYS = 6'h06;
  localparam logic [5:0] IDX_CONTROL   = 6'h20;
  localparam logic [5:0] IDX_FLAGS     = 6'h21;
  localparam logic [5:0] IDX_CNT_HIGH  = 6'h22;
  localparam logic [5:0] IDX_CNT_LOW   = 6'h23;
  localparam logic [5:0] IDX_CNT_WORD  = 6'h24;

  // accum_control fields
  localparam int CTL_ENABLE  = 6;
  localparam int CTL_MODE    = 5;
  localparam int CTL_EDGE    = 4;
  localparam int CTL_CLK_HI  = 3;
  localparam int CTL_CLK_LO  = 2;
  localparam int CTL_OVF_IE  = 1;
  localparam int CTL_IN_IE   = 0;

  // accum_flags fields
  localparam int FLG_OVF     = 1;
  localparam int FLG_IN      = 0;

  // timer_system_control fields
  localparam int TSC_TEN     = 7;
  localparam int TSC_FFC     = 4;

  // clock select encodings
  localparam logic [1:0] CLK_PRESCALER = 2'h0;
  localparam logic [1:0] CLK_ACCUM     = 2'h1;
  localparam logic [1:0] CLK_ACCUM_256 = 2'h2;
  localparam logic [1:0] CLK_ACCUM_64K = 2'h3;

  // reset values and timing
  localparam logic [6:0]  CONTROL_RST = 7'h00;
  localparam logic [1:0]  FLAGS_RST   = 2'h0;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [5:0]  DIV64_LAST  = 6'h3F;
  localparam logic [7:0]  DIV256_LAST = 8'hFF;

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic [6:0]  ctl;
    logic [1:0]  flags;
    logic [15:0] cnt;
    logic        timer_enable;
    logic        ffc;
    logic [5:0]  presc;
    logic [15:0] clkdiv;
    logic [31:0] rdata;
    logic        slverr;
    logic        irq_ovf;
    logic        irq_in;
    logic        tclk;
  } pa_state_type;

endpackage

/* File: sim/pa_accum_properties.sv */
// checker: port-level properties of the pulse accumulator
// assumes binding onto pa_accum; control is shadowed from apb writes
`timescale 1ns/10ps
module pa_props (
  // clock, reset, bus
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pin, tick and outputs
  input wire logic        CH7_PIN,
  input wire logic        PRESCALER_TICK,
  input wire logic        TCNT_CLK_EN,
  input wire logic        PA_OVF_IRQ,
  input wire logic        PA_IN_IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  logic [6:0] ctl_ff;
  logic       ten_ff;
  wire        wr = PSEL && PENABLE && PWRITE;
  wire        wr_ctl = wr && PADDR == 8'h80;
  // shadow copies so rules can be judged from the ports alone
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctl_ff <= 7'h00;
      ten_ff <= 1'b0;
    end else begin
      if (wr_ctl) ctl_ff <= PWDATA[6:0];
      if (wr && PADDR == 8'h18) ten_ff <= PWDATA[7];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // the release edge itself still resets the design, so no attempt may start on it
  property p_presc; !SYS_RST && (!ctl_ff[6] || ctl_ff[3:2] == 2'h0) && !wr_ctl
    |=> TCNT_CLK_EN == $past(PRESCALER_TICK); endproperty
  a_presc: assert property (p_presc) else $error("timer clock not prescaler");
  property p_no_gate; ctl_ff[6:5] == 2'h3 && ctl_ff[3:2] == 2'h1 && !ten_ff && !wr
    |=> !TCNT_CLK_EN; endproperty
  a_no_gate: assert property (p_no_gate) else $error("gated tick while timer off");
  property p_ovf; PA_OVF_IRQ |-> ctl_ff[1] || $past(ctl_ff[1]); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow irq while disabled");
  property p_in; PA_IN_IRQ |-> ctl_ff[0] || $past(ctl_ff[0]); endproperty
  a_in: assert property (p_in) else $error("input irq while disabled");
  property p_err; PSEL && PENABLE |-> PSLVERR == (PADDR[1:0] != 2'h0
    || !(PADDR[7:2] inside {6'h06, [6'h20:6'h24]})); endproperty
  a_err: assert property (p_err) else $error("wrong error response");
  property p_err_rd; PSEL && PENABLE && !PWRITE && PSLVERR |-> PRDATA == 32'h0; endproperty
  a_err_rd: assert property (p_err_rd) else $error("refused read not zero");
  property p_rdy; PSEL && PENABLE |-> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("missing ready");
  property p_ev; ctl_ff[6:4] == 3'h5 && ctl_ff[0] && $rose(CH7_PIN) |-> ##[2:4] PA_IN_IRQ;
  endproperty
  a_ev: assert property (p_ev) else $error("rising edge not flagged");
endmodule
bind pa_accum pa_props u_props (.*);

/* File: sim/pa_pin_src.sv */
// partner: external pulse source on the channel 7 pin
// assumes calls start right after a rising edge
`timescale 1ns/10ps
module pa_pin_src (
  // clock and pin
  input wire logic clk,
  output logic     pin
);
  initial pin = 1'b0;
  task automatic pulse(input int cyc);
    @(posedge clk);
    pin <= 1'b1;
    repeat (cyc) @(posedge clk);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: sim/pulse_accumulator_16bit_bench.sv */
// bench: apb traffic and pin pulses against pa_accum
// assumes pa_props bound in and pa_pin_src on the pin
`timescale 1ns/10ps
module pulse_accumulator_16bit_bench;
  logic        clk, rst, psel, pen, pwr, tick, pready, pslverr, pin, tclk, ovf_irq, in_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  logic [15:0] c0;
  int          k, t0, n_errors, total_checks;
  int          n_tclk = 0;
  pa_accum DUT (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CH7_PIN(pin), .PRESCALER_TICK(tick), .TCNT_CLK_EN(tclk), .PA_OVF_IRQ(ovf_irq),
    .PA_IN_IRQ(in_irq));
  pa_pin_src u_src (.clk(clk), .pin(pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tick <= ($urandom % 3) == 0;
  // running count of timer clock enables, sampled as differences around a burst
  always @(posedge clk) if (tclk === 1'b1) n_tclk <= n_tclk + 1;
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle cycle before setup avoids a same-step reassignment of psel
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      print_verdict();
    end
  endtask
  function automatic logic [31:0] flg(input logic [15:0] c, input int n);
    return {30'h0, 17'(c) + 17'(n) > 17'hFFFF, 1'b1};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    total_checks = 0;
    {rst, psel, pen, pwr, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
    void'($urandom(34));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'h80 + 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'hC0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 8'h81, 32'h7F);
    chk({rd[30:0], er}, 32'h1);
    c0 = 16'($urandom);
    apb(1'b1, 8'h90, {16'h0, c0});
    u_src.pulse(8);
    apb(1'b0, 8'h88, 32'h0);
    chk(rd, {24'h0, c0[15:8]});
    apb(1'b0, 8'h8C, 32'h0);
    chk(rd, {24'h0, c0[7:0]});
    // event mode near rollover, every clock select, both edges
    for (int i = 0; i < 4; i++) begin
      c0 = 16'hFFFF - 16'($urandom % 3);
      k = 1 + $urandom % 3;
      apb(1'b1, 8'h90, {16'h0, c0});
      apb(1'b1, 8'h80, 32'h43 | (i << 2) | ((i % 2) << 4));
      // an enable launched under the old select drains before the baseline
      repeat (2) @(posedge clk);
      t0 = n_tclk;
      repeat (k) u_src.pulse(3 + $urandom % 4);
      repeat (3) @(posedge clk);
      if (i > 0) chk(n_tclk - t0, (i == 1) ? k : 0);
      apb(1'b0, 8'h90, 32'h0);
      chk(rd, {16'h0, 16'(c0 + 16'(k))});
      apb(1'b0, 8'h84, 32'h0);
      chk(rd, flg(c0, k));
      chk({30'h0, ovf_irq, in_irq}, flg(c0, k));
      if (i % 2) begin
        apb(1'b1, 8'h18, 32'h10);
        apb(1'b0, 8'h88, 32'h0);
        apb(1'b1, 8'h18, 32'h0);
      end else apb(1'b1, 8'h84, 32'h3);
      apb(1'b0, 8'h84, 32'h0);
      chk(rd, 32'h0);
    end
    // gated mode: nothing while the timer is stopped, then about one per 64
    apb(1'b1, 8'h90, 32'h0);
    apb(1'b1, 8'h80, 32'h64);
    u_src.pulse(130);
    apb(1'b0, 8'h90, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h84, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h18, 32'h80);
    u_src.pulse(200);
    apb(1'b0, 8'h90, 32'h0);
    chk(32'(rd >= 2 && rd <= 4), 32'h1);
    print_verdict();
  end
endmodule
